// >>> bench/mdio_station.sv
// Purpose: management station model driving mdc and the shared mdio line
// Assumes: paced on core clock falling edges, 4 clocks per mdc phase
// Notes: mdc stands low between frames; released line reads high
`timescale 1ns/1ps

module mdio_station import phy_regs_pkg::*; (
  // pacing clock
  input wire logic clk,
  // management pins
  output logic mdc,
  output logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  logic drv_en;
  logic drv;

  // wired line: device, station, else the pull-up
  assign mdio_i = mdio_oe ? mdio_o : (drv_en ? drv : 1'b1);

  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv = 1'b1;
  end

  // one bit: drive in the low phase, sample just before the rise
  task automatic clock_bit(input logic en, input logic v, output logic s);
    mdc = 1'b0;
    drv_en = en;
    drv = v;
    repeat (4) @(negedge clk);
    s = mdio_i;
    mdc = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  // whole frame; read data bits arrive one rise after they are launched
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [45:0] hdr;
    logic [17:0] tail;
    logic s;
    hdr = {32'hffff_ffff, 2'b01, op, pa, ra};
    tail = {2'b10, wd};
    rd = 16'h0000;
    @(negedge clk);
    for (int i = 45; i >= 0; i--) begin
      clock_bit(1'b1, hdr[i], s);
    end
    for (int j = 0; j < 18; j++) begin
      clock_bit(op != OP_READ, tail[17-j], s);
      if (j >= 2) begin
        rd[17-j] = s;
      end
    end
    mdc = 1'b0;
    drv_en = 1'b0;
  endtask

  // preamble, then a zero where the second start bit belongs
  task automatic bad_start();
    logic s;
    @(negedge clk);
    for (int i = 0; i < 46; i++) begin
      clock_bit(1'b1, i < 32, s);
    end
    mdc = 1'b0;
    drv_en = 1'b0;
  endtask
endmodule

// >>> bench/phy_link_irq_mask_regs_test.sv
// Purpose: register, interrupt and retry tests over the management pins
// Assumes: own phy address 5'h05; each frame near 530 core clocks
// Notes: a second reset in mid-run rechecks the reset image
`timescale 1ns/1ps

module phy_link_irq_mask_regs_test import phy_regs_pkg::*; ;
  logic clk, rst_n, mdc, mdio_i, mdio_o, mdio_oe;
  logic fast_en, attempt_fail, link_up, allow, standby, diag;
  logic fallback, int_n_o, int_n_oe;
  logic [4:0] phy_addr;
  logic [EVT_W-1:0] core_events;
  logic [RETRY_W-1:0] limit;
  logic [3:0] fails;
  logic [15:0] rd, bitv;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;

  phy_link_irq_mask_regs uut (.clk(clk), .rst_n(rst_n), .mdc(mdc),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .phy_addr(phy_addr), .core_events(core_events),
    .fallback_fast_enable(fast_en), .attempt_fail(attempt_fail),
    .link_up(link_up), .link_attempt_enable(allow), .standby(standby),
    .diag_allowed(diag), .retry_limit(limit), .fallback_active(fallback),
    .fail_count(fails), .int_n_o(int_n_o), .int_n_oe(int_n_oe));
  mdio_station mgr (.clk(clk), .mdc(mdc), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe));

  always #4 clk = ~clk;

  // hang guard; the full run needs about 35000 clocks
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
      input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // settle time covers sync, register update and pin path
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] d);
    mgr.frame(OP_WRITE, pa, ra, d, rd);
    repeat (8) @(negedge clk);
  endtask

  task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
    mgr.frame(OP_READ, phy_addr, ra, 16'h0000, rd);
    repeat (8) @(negedge clk);
    chk($sformatf("reg %h", ra), e, rd);
  endtask

  task automatic fail_n(input int n);
    repeat (n) begin
      @(negedge clk) attempt_fail = 1'b1;
      @(negedge clk) attempt_fail = 1'b0;
    end
    repeat (2) @(negedge clk);
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    core_events = '0;
    {fast_en, attempt_fail, link_up} = 3'b000;
    phy_addr = 5'h05;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("allow", 16'h0001, allow);
    chk("standby", 16'h0000, standby);
    chk("limit", 16'h0004, limit);
    rdc(ADDR_LINK_RETRY, 16'h3048);
    rdc(ADDR_INT_ENABLE, 16'h0000);
    rdc(ADDR_INT_STATUS, 16'h0000);
    rdc(5'h1a, 16'h0000);
    wr(phy_addr, ADDR_LINK_RETRY, 16'hffff);
    rdc(ADDR_LINK_RETRY, 16'h3fff);
    chk("limit", 16'h0007, limit);
    wr(phy_addr, ADDR_INT_ENABLE, 16'hffff);
    wr(phy_addr ^ 5'h01, ADDR_INT_ENABLE, 16'h0000);
    rdc(ADDR_INT_ENABLE, 16'hffff);
    chk("int idle", 16'h0000, int_n_oe);
    // each source: masked, enabled, pin off, then read-clear
    for (int i = 0; i < EVT_W; i++) begin
      bitv = 16'h0002 << i;
      wr(phy_addr, ADDR_INT_ENABLE, 16'h0001);
      @(negedge clk) core_events = EVT_W'(1) << i;
      @(negedge clk) core_events = '0;
      repeat (4) @(negedge clk);
      chk("int masked", 16'h0000, int_n_oe);
      wr(phy_addr, ADDR_INT_ENABLE, bitv | 16'h0001);
      chk("int on", 16'h0001, int_n_oe);
      wr(phy_addr, ADDR_INT_ENABLE, bitv);
      chk("int pin off", 16'h0000, int_n_oe);
      rdc(ADDR_INT_STATUS, bitv);
      rdc(ADDR_INT_STATUS, 16'h0000);
    end
    // a zero second start bit drops the frame and flags lost sync
    wr(phy_addr, ADDR_INT_ENABLE, 16'h0201);
    mgr.bad_start();
    repeat (8) @(negedge clk);
    chk("sync lost", 16'h0001, int_n_oe);
    rdc(ADDR_INT_STATUS, 16'h0200);
    chk("int cleared", 16'h0000, int_n_oe);
    // retries: no fallback while downspeed is off
    wr(phy_addr, ADDR_LINK_RETRY, 16'h3048);
    fail_n(6);
    chk("fallback", 16'h0000, fallback);
    chk("count", 16'h0006, fails);
    @(negedge clk) link_up = 1'b1;
    @(negedge clk) link_up = 1'b0;
    @(negedge clk);
    chk("count", 16'h0000, fails);
    fast_en = 1'b1;
    fail_n(4);
    chk("fallback", 16'h0000, fallback);
    fail_n(1);
    chk("fallback", 16'h0001, fallback);
    wr(phy_addr, ADDR_LINK_RETRY, 16'h0448);
    chk("fallback", 16'h0000, fallback);
    chk("standby", 16'h0001, standby);
    chk("diag", 16'h0001, diag);
    fail_n(2);
    chk("count", 16'h0000, fails);
    wr(phy_addr, ADDR_LINK_RETRY, 16'h2448);
    fail_n(1);
    chk("fallback", 16'h0000, fallback);
    fail_n(1);
    chk("fallback", 16'h0001, fallback);
    // second reset in mid-run
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    rdc(ADDR_LINK_RETRY, 16'h3048);
    rdc(ADDR_INT_ENABLE, 16'h0000);
    chk("fallback", 16'h0000, fallback);
    chk("limit", 16'h0004, limit);
    complete_run();
  end
endmodule

bind phy_link_irq_mask_regs phy_link_irq_monitor #(.CNT_W(CNT_W)) mon (
  .clk(clk), .rst_n(rst_n), .mdc(mdc), .core_events(core_events),
  .fallback_fast_enable(fallback_fast_enable), .attempt_fail(attempt_fail),
  .link_up(link_up), .link_attempt_enable(link_attempt_enable),
  .standby(standby), .diag_allowed(diag_allowed),
  .retry_limit(retry_limit), .fallback_active(fallback_active),
  .fail_count(fail_count), .int_n_o(int_n_o), .int_n_oe(int_n_oe));

// >>> bench/phy_link_irq_monitor.sv
// Purpose: port checker for the link retry and interrupt bank
// Assumes: one core clock, async active-low reset
// Notes: pin changes must trace back to an event or a frame
`timescale 1ns/1ps

module phy_link_irq_monitor import phy_regs_pkg::*; #(
  parameter int CNT_W = RETRY_W + 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // inputs watched
  input wire logic mdc,
  input wire logic [EVT_W-1:0] core_events,
  input wire logic fallback_fast_enable,
  input wire logic attempt_fail,
  input wire logic link_up,
  // outputs watched
  input wire logic link_attempt_enable,
  input wire logic standby,
  input wire logic diag_allowed,
  input wire logic [RETRY_W-1:0] retry_limit,
  input wire logic fallback_active,
  input wire logic [CNT_W-1:0] fail_count,
  input wire logic int_n_o,
  input wire logic int_n_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic any_evt;
  logic mdc_q;
  logic [5:0] gap_q;
  assign any_evt = |core_events;

  // clocks since mdc rose; saturates so an idle bus reads as far away
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdc_q <= 1'b0;
      gap_q <= 6'h3f;
    end else begin
      mdc_q <= mdc;
      if (mdc && !mdc_q) begin
        gap_q <= 6'h00;
      end else if (gap_q != 6'h3f) begin
        gap_q <= gap_q + 6'h01;
      end
    end
  end

  link_standby_a: assert property (standby == !link_attempt_enable)
    else $error("standby does not mirror link allow");
  diag_window_a: assert property (diag_allowed == standby)
    else $error("diagnostics not tied to standby");
  pin_level_a: assert property (int_n_o == 1'b0)
    else $error("interrupt pin drive level not low");
  int_rise_a: assert property ($rose(int_n_oe) |-> $past(any_evt) ||
    $past(any_evt, 2) || $past(any_evt, 3) || gap_q < 6'h10)
    else $error("interrupt rose without event or frame");
  int_fall_a: assert property ($fell(int_n_oe) |-> gap_q < 6'h10)
    else $error("interrupt fell without a frame");
  fallback_rise_a: assert property ($rose(fallback_active) |->
    $past(attempt_fail) && $past(fallback_fast_enable) && fail_count == '0)
    else $error("fallback without enabled failed attempt");
  count_step_a: assert property (attempt_fail && link_attempt_enable &&
    !link_up && !fallback_active && fail_count < retry_limit
    |=> fail_count == $past(fail_count) + 1'b1)
    else $error("failed attempt not counted");
  standby_clear_a: assert property (!link_attempt_enable [*2] |->
    fail_count == '0 && !fallback_active)
    else $error("retry state kept in standby");
  link_up_clear_a: assert property (link_up |=> fail_count == '0)
    else $error("link up did not clear count");
endmodule

// >>> common/phy_regs_pkg.sv
// Purpose: shared constants for the link retry and interrupt enable bank
// Assumes: 16-bit management registers, 5-bit register addresses
// Notes: event vectors index 0 maps to register bit 1

package phy_regs_pkg;

  // register geometry and addresses
  localparam int REG_W = 16;
  localparam logic [4:0] ADDR_LINK_RETRY = 5'h17;
  localparam logic [4:0] ADDR_INT_ENABLE = 5'h18;
  localparam logic [4:0] ADDR_INT_STATUS = 5'h19;

  // reset values
  localparam logic [15:0] LINK_RETRY_RESET = 16'h3048;
  localparam logic [15:0] INT_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;

  // link retry control fields; bits 15:14 never stored
  localparam int RETRY_STORE_W = 14;
  localparam int LINK_ALLOW_BIT = 13;
  localparam int RETRY_LSB = 10;
  localparam int RETRY_W = 3;

  // interrupt enable and status bit positions
  localparam int PIN_EN_BIT = 0;
  localparam int RATE_CHG_BIT = 1;
  localparam int LINK_CHG_BIT = 2;
  localparam int RX_CHG_BIT = 3;
  localparam int MAC_FIFO_BIT = 4;
  localparam int IDLE_SAT_BIT = 5;
  localparam int PAGE_RX_BIT = 6;
  localparam int FGC_BIT = 7;
  localparam int NEG_CHG_BIT = 8;
  localparam int SYNC_LOST_BIT = 9;
  localparam int CABLE_BIT = 10;
  localparam int EVT_LSB = 1;
  localparam int EVT_MSB = 10;
  localparam int EVT_W = EVT_MSB - EVT_LSB + 1;

  // management frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST = 5'h0c;
  localparam logic [4:0] RD_LAST = 5'h11;
  localparam logic [4:0] WR_LAST = 5'h11;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  // management frame states
  typedef enum logic [3:0] {
    ST_PRE = 4'h1,
    ST_HDR = 4'h2,
    ST_WR = 4'h4,
    ST_RD = 4'h8
  } mdio_state_t;

endpackage

// >>> common/status_if.sv
// Purpose: carries event, enable and latched status between bank and latch
// Assumes: all signals on the core clock
// Notes: clear_all is combinational from the frame decoder
`timescale 1ns/1ps

interface status_if import phy_regs_pkg::*; ();
  logic [EVT_W-1:0] event_pulse;
  logic [EVT_W-1:0] enables;
  logic clear_all;
  logic [EVT_W-1:0] flags;
  logic pending;

  modport owner (output event_pulse, output enables, output clear_all,
                 input flags, input pending);
  modport latch (input event_pulse, input enables, input clear_all,
                 output flags, output pending);
endinterface

// >>> src/event_latch.sv
// Purpose: sticky event flags with read-clear and masked pending summary
// Assumes: event pulses and clear come from the core clock domain
// Notes: a set in the clearing cycle survives the clear
`timescale 1ns/1ps

module event_latch import phy_regs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // status group
  status_if.latch sif
);

  typedef struct packed {
    logic [EVT_W-1:0] flags;
    logic pending;
  } latch_state_t;

  latch_state_t s_q;
  latch_state_t s_d;

  // flags latch regardless of enables; only enabled ones reach pending
  always_comb begin
    s_d = s_q;
    s_d.flags = (s_q.flags & ~{EVT_W{sif.clear_all}})
      | sif.event_pulse; // [R18]
    s_d.pending = |(s_d.flags & sif.enables); // [R19]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sif.flags = s_q.flags;
  assign sif.pending = s_q.pending;

endmodule

// >>> src/link_retry_seq.sv
// Purpose: counts failed link attempts and decides when to drop speed
// Assumes: attempt_fail is a one-cycle pulse from the link machinery
// Notes: fallback holds until link allow is withdrawn
`timescale 1ns/1ps

module link_retry_seq import phy_regs_pkg::*; #(
  parameter int CNT_W = RETRY_W + 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls
  input wire logic link_allow,
  input wire logic fallback_enable,
  input wire logic [RETRY_W-1:0] retry_limit,
  // link machinery
  input wire logic attempt_fail,
  input wire logic link_up,
  // results
  output logic fallback_active,
  output logic [CNT_W-1:0] fail_count
);

  typedef struct packed {
    logic [CNT_W-1:0] fails;
    logic fallback;
  } retry_state_t;

  retry_state_t s_q;
  retry_state_t s_d;

  // retry limit failures tolerated; one more drops the advertised speed
  always_comb begin
    s_d = s_q;
    if (!link_allow) begin
      s_d.fails = '0; // [R2]
      s_d.fallback = 1'b0;
    end else if (link_up) begin
      s_d.fails = '0;
    end else if (attempt_fail && !s_q.fallback) begin
      if (fallback_enable && s_q.fails >= CNT_W'(retry_limit)) begin
        s_d.fallback = 1'b1; // [R4] [R21]
        s_d.fails = '0;
      end else if (s_q.fails != {CNT_W{1'b1}}) begin
        s_d.fails = s_q.fails + CNT_W'(1); // [R4]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign fallback_active = s_q.fallback;
  assign fail_count = s_q.fails;

endmodule

// >>> src/phy_link_irq_mask_regs.sv
// Purpose: link retry control and interrupt enable registers behind MDIO
// Assumes: mdc far slower than clk; pins synchronised by two flip-flops
// Notes: status register at its own address is read-only, read clears it
//
// Summary of operation
// [R1] link attempts only while link-allow bit set
// [R2] cleared link-allow holds device in standby
// [R3] standby permits cable diagnostics to run
// [R4] retry count field sets attempts before downspeed
// [R5] link retry register resets to 0x3048
// [R6] interrupt enable register resets to zero
// [R7] bit 10 gates cable diagnostics event
// [R8] bit 9 gates management sync lost event
// [R9] bit gates negotiation status change event
// [R10] bit gates frame generator checker event
// [R11] bit 6 gates page received event
// [R12] bit 5 gates idle error saturation event
// [R13] bit 4 gates mac fifo flow event
// [R14] bit 3 gates receive status change event
// [R15] bit 2 gates link status change event
// [R16] bit 1 gates rate change event
// [R17] bit 0 enables the interrupt pin
// [R18] flags latch; any status read clears all
// [R19] flags set always; pending uses enabled only
// [R20] frame generator checker sits at bit 7
// [R21] exhausted retries fall back to lower speed
// [R22] negotiation change enable sits at bit 8
// [R23] pin low when enabled and enabled flag pending
`timescale 1ns/1ps

module phy_link_irq_mask_regs import phy_regs_pkg::*; #(
  parameter int CNT_W = RETRY_W + 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  // event pulses from the core, index 0 is register bit 1
  input wire logic [EVT_W-1:0] core_events,
  // link machinery
  input wire logic fallback_fast_enable,
  input wire logic attempt_fail,
  input wire logic link_up,
  // control outputs
  output logic link_attempt_enable,
  output logic standby,
  output logic diag_allowed,
  output logic [RETRY_W-1:0] retry_limit,
  output logic fallback_active,
  output logic [CNT_W-1:0] fail_count,
  // open-drain interrupt pin
  output logic int_n_o,
  output logic int_n_oe
);

  typedef struct packed {
    mdio_state_t st;
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_prev;
    logic mdio_s1;
    logic mdio_s2;
    logic [4:0] addr_s1;
    logic [4:0] addr_s2;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [11:0] hdr;
    logic [15:0] shreg;
    logic [4:0] reg_sel;
    logic [RETRY_STORE_W-1:0] retry_ctl;
    logic [15:0] int_en;
    logic mdio_o;
    logic mdio_oe;
    logic int_oe;
  } top_state_t;

  localparam top_state_t STATE_RESET = '{
    st: ST_PRE,
    mdc_s1: 1'b0,
    mdc_s2: 1'b0,
    mdc_prev: 1'b0,
    mdio_s1: 1'b1,
    mdio_s2: 1'b1,
    addr_s1: 5'h00,
    addr_s2: 5'h00,
    ones: 6'h00,
    cnt: 5'h00,
    hdr: 12'h000,
    shreg: 16'h0000,
    reg_sel: 5'h00,
    retry_ctl: LINK_RETRY_RESET[RETRY_STORE_W-1:0], // [R5]
    int_en: INT_ENABLE_RESET, // [R6]
    mdio_o: 1'b0,
    mdio_oe: 1'b0,
    int_oe: 1'b0
  };

  top_state_t s_q;
  top_state_t s_d;
  logic read_clear;
  logic [EVT_W-1:0] evt;
  logic mdc_rise;
  logic [12:0] hdr_full;
  logic [15:0] wr_full;

  status_if sif ();

  // register read decode; unmapped addresses answer zero
  function automatic logic [15:0] read_value(
    input logic [4:0] addr,
    input logic [RETRY_STORE_W-1:0] retry,
    input logic [15:0] en,
    input logic [EVT_W-1:0] flags
  );
    logic [15:0] v;
    v = UNMAPPED_READ;
    case (addr)
      ADDR_LINK_RETRY: begin
        v = {2'b00, retry}; // [R5]
      end
      ADDR_INT_ENABLE: begin
        v = en;
      end
      ADDR_INT_STATUS: begin
        v = {5'h00, flags, 1'b0}; // [R20] [R22]
      end
      default: begin
        v = UNMAPPED_READ;
      end
    endcase
    return v;
  endfunction

  // sticky status flags live in their own small block
  event_latch u_latch (
    .clk(clk),
    .rst_n(rst_n),
    .sif(sif)
  );

  // retry counting and speed fallback
  link_retry_seq #(
    .CNT_W(CNT_W)
  ) u_retry (
    .clk(clk),
    .rst_n(rst_n),
    .link_allow(s_q.retry_ctl[LINK_ALLOW_BIT]),
    .fallback_enable(fallback_fast_enable),
    .retry_limit(s_q.retry_ctl[RETRY_LSB +: RETRY_W]),
    .attempt_fail(attempt_fail),
    .link_up(link_up),
    .fallback_active(fallback_active),
    .fail_count(fail_count)
  );

  // event vector: frame sync loss from this decoder joins the core's
  always_comb begin
    evt = core_events; // [R7] [R11] [R12] [R13] [R14] [R15] [R16]
    evt[SYNC_LOST_BIT-EVT_LSB] = core_events[SYNC_LOST_BIT-EVT_LSB]
      | (s_q.st == ST_HDR && mdc_rise && s_q.cnt == HDR_LAST
         && !s_q.hdr[11]); // [R8]
  end

  // enables share the status layout, bits 10 down to 1
  assign sif.event_pulse = evt;
  assign sif.enables = s_q.int_en[EVT_MSB:EVT_LSB]; // [R9] [R10] [R22]
  assign sif.clear_all = read_clear;

  // edge of the synchronised management clock, read after the second stage
  assign mdc_rise = s_q.mdc_s2 & ~s_q.mdc_prev;
  assign hdr_full = {s_q.hdr, s_q.mdio_s2};
  assign wr_full = {s_q.shreg[14:0], s_q.mdio_s2};

  // frame decoder, register writes and pin drive
  always_comb begin
    s_d = s_q;
    read_clear = 1'b0;
    s_d.mdc_s1 = mdc;
    s_d.mdc_s2 = s_q.mdc_s1;
    s_d.mdc_prev = s_q.mdc_s2;
    s_d.mdio_s1 = mdio_i;
    s_d.mdio_s2 = s_q.mdio_s1;
    s_d.addr_s1 = phy_addr;
    s_d.addr_s2 = s_q.addr_s1;
    if (mdc_rise) begin
      case (s_q.st)
        ST_PRE: begin
          // count ones; a zero after a full preamble is the start bit
          if (s_q.mdio_s2) begin
            if (s_q.ones != PREAMBLE_LEN) begin
              s_d.ones = s_q.ones + 6'h01;
            end
          end else begin
            if (s_q.ones == PREAMBLE_LEN) begin
              s_d.st = ST_HDR;
              s_d.cnt = 5'h00;
              s_d.hdr = 12'h000;
            end
            s_d.ones = 6'h00;
          end
        end
        ST_HDR: begin
          s_d.hdr = hdr_full[11:0];
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == HDR_LAST) begin
            s_d.st = ST_PRE;
            s_d.cnt = 5'h00;
            s_d.reg_sel = hdr_full[4:0];
            // a bad second start bit counts as lost sync
            if (hdr_full[12] && hdr_full[9:5] == s_q.addr_s2) begin
              if (hdr_full[11:10] == OP_READ) begin
                s_d.st = ST_RD;
                s_d.shreg = read_value(hdr_full[4:0], s_q.retry_ctl,
                                       s_q.int_en, sif.flags);
                // clear in the capture cycle so no event slips between
                read_clear = (hdr_full[4:0] == ADDR_INT_STATUS); // [R18]
              end else if (hdr_full[11:10] == OP_WRITE) begin
                s_d.st = ST_WR;
              end
            end
          end
        end
        ST_WR: begin
          // the two turnaround bits shift out past the top
          s_d.shreg = wr_full;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == WR_LAST) begin
            s_d.st = ST_PRE;
            s_d.cnt = 5'h00;
            if (s_q.reg_sel == ADDR_LINK_RETRY) begin
              s_d.retry_ctl = wr_full[RETRY_STORE_W-1:0]; // [R1] [R4]
            end else if (s_q.reg_sel == ADDR_INT_ENABLE) begin
              s_d.int_en = wr_full; // reserved bits are plain storage
            end
          end
        end
        ST_RD: begin
          // zero turnaround bit, then sixteen bits msb first
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'h00) begin
            s_d.mdio_oe = 1'b1;
            s_d.mdio_o = 1'b0;
          end else if (s_q.cnt == RD_LAST) begin
            s_d.mdio_oe = 1'b0;
            s_d.mdio_o = 1'b0;
            s_d.st = ST_PRE;
            s_d.cnt = 5'h00;
          end else begin
            s_d.mdio_o = s_q.shreg[15];
            s_d.shreg = {s_q.shreg[14:0], 1'b0};
          end
        end
        default: begin
          s_d.st = ST_PRE;
          s_d.cnt = 5'h00;
          s_d.mdio_oe = 1'b0;
        end
      endcase
    end
    // pin pulls low only while its enable and an enabled flag both stand
    s_d.int_oe = s_q.int_en[PIN_EN_BIT] & sif.pending; // [R17] [R23]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // management pin drive
  assign mdio_o = s_q.mdio_o;
  assign mdio_oe = s_q.mdio_oe;

  // link control outputs straight from the stored register
  assign link_attempt_enable = s_q.retry_ctl[LINK_ALLOW_BIT]; // [R1]
  assign standby = ~s_q.retry_ctl[LINK_ALLOW_BIT]; // [R2]
  assign diag_allowed = ~s_q.retry_ctl[LINK_ALLOW_BIT]; // [R3]
  assign retry_limit = s_q.retry_ctl[RETRY_LSB +: RETRY_W]; // [R4]

  // open-drain: level always low, only the enable moves
  assign int_n_o = 1'b0;
  assign int_n_oe = s_q.int_oe; // [R23]

endmodule
